// ===== regulator_ov_uv_monitor.sv
// Digital overvoltage and undervoltage supervisor for three buck regulators.
// Assumes comparator, rail-on and in-regulation levels arrive asynchronously from the analog
// side, while configuration strobes come from logic on clk_sys_in.
`timescale 1ns/10ps

module regulator_ov_uv_monitor (
  input wire logic clk_sys_in, // System clock, 40 MHz.
  input wire logic rst_in, // Synchronous reset, active high.
  input regulator_monitor_pkg::comparator_pair_t [2:0] comparator_in, // Async comparator levels.
  input wire logic [2:0] regulator_on_in, // Async level, high while a regulator is switched on.
  input wire logic [2:0] in_regulation_in, // Async level, high once a rail is in regulation.
  input wire logic [2:0][1:0] undervoltage_threshold_select_in, // Per-rail UV level code.
  input wire logic [2:0][1:0] overvoltage_threshold_select_in, // Per-rail OV level code.
  input wire logic debounce_write_in, // One-cycle strobe loading both debounce selects.
  input wire logic [1:0] undervoltage_debounce_select_in, // UV debounce code to load.
  input wire logic [1:0] overvoltage_debounce_select_in, // OV debounce code to load.
  input wire logic secure_protect_in, // High while enable changes need a secure write.
  input wire logic monitor_enable_write_in, // One-cycle strobe writing the enable bits.
  input wire logic monitor_enable_secure_in, // High when that write is a secure write.
  input wire logic [2:0] monitor_enable_wdata_in, // New per-regulator enable values.
  output regulator_monitor_pkg::threshold_pair_t [2:0] threshold_percent_out, // Trip levels.
  output logic [1:0] undervoltage_debounce_select_out, // Current UV debounce code.
  output logic [1:0] overvoltage_debounce_select_out, // Current OV debounce code.
  output logic [2:0] per_regulator_monitor_enable_out, // Current enable bits.
  output logic [2:0] monitor_masked_out, // High while a rail's monitoring is masked.
  output logic [2:0] undervoltage_status_out, // Debounced undervoltage indicators.
  output logic [2:0] overvoltage_status_out // Debounced overvoltage indicators.
);

  // Number of asynchronous levels brought into the clock domain.
  localparam int SYNC_W = 4 * regulator_monitor_pkg::NUM_REGULATORS;

  logic [SYNC_W-1:0] async_level; // All analog levels gathered for synchronisation.
  logic [SYNC_W-1:0] sync_stage1; // First synchroniser stage, read only by the second.
  logic [SYNC_W-1:0] sync_stage2; // Synchronised copies used by the logic.
  logic [regulator_monitor_pkg::TICK_CNT_W-1:0] tick_count; // Divider toward the tick.
  logic tick; // One-cycle pulse at 100 kHz.
  logic [1:0] uv_debounce_select; // Stored UV debounce code.
  logic [1:0] ov_debounce_select; // Stored OV debounce code.
  logic [2:0] monitor_enable; // Stored per-regulator enable bits.
  logic [regulator_monitor_pkg::DB_CNT_W-1:0] uv_target; // UV debounce length in ticks.
  logic [regulator_monitor_pkg::DB_CNT_W-1:0] ov_target; // OV debounce length in ticks.
  logic enable_write_ok; // The enable write in this cycle is allowed.

  assign async_level = {in_regulation_in, regulator_on_in, comparator_in};

  // Two flip-flops per analog level, since none of these share the system clock.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sync_stage1 <= '0;
      sync_stage2 <= '0;
    end else begin
      sync_stage1 <= async_level;
      sync_stage2 <= sync_stage1;
    end
  end

  // Divide the system clock down to the slow control tick.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      tick_count <= '0;
      tick <= 1'b0;
    end else if (tick_count == regulator_monitor_pkg::TICK_LAST) begin
      tick_count <= '0;
      tick <= 1'b1;
    end else begin
      tick_count <= tick_count + 1'b1;
      tick <= 1'b0;
    end
  end

  // Debounce selects load on their strobe; both are shared by all regulators.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      uv_debounce_select <= regulator_monitor_pkg::UV_DEBOUNCE_RESET;
      ov_debounce_select <= regulator_monitor_pkg::OV_DEBOUNCE_RESET;
    end else if (debounce_write_in) begin
      uv_debounce_select <= undervoltage_debounce_select_in;
      ov_debounce_select <= overvoltage_debounce_select_in;
    end
  end

  // An unprotected write always lands; a protected one lands only when it is secure.
  assign enable_write_ok = monitor_enable_write_in &
                           (~secure_protect_in | monitor_enable_secure_in);

  // Enable bits; a refused write is silently dropped and the old bits stay.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      monitor_enable <= regulator_monitor_pkg::MONITOR_ENABLE_RESET;
    end else if (enable_write_ok) begin
      monitor_enable <= monitor_enable_wdata_in;
    end
  end

  // Map the debounce codes onto tick counts.
  always_comb begin
    unique case (uv_debounce_select)
      2'h0: uv_target = regulator_monitor_pkg::UV_TICKS_00;
      2'h1: uv_target = regulator_monitor_pkg::UV_TICKS_01;
      2'h2: uv_target = regulator_monitor_pkg::UV_TICKS_10;
      2'h3: uv_target = regulator_monitor_pkg::UV_TICKS_11;
    endcase
    unique case (ov_debounce_select)
      2'h0: ov_target = regulator_monitor_pkg::OV_TICKS_00;
      2'h1: ov_target = regulator_monitor_pkg::OV_TICKS_01;
      2'h2: ov_target = regulator_monitor_pkg::OV_TICKS_10;
      2'h3: ov_target = regulator_monitor_pkg::OV_TICKS_11;
    endcase
  end

  assign undervoltage_debounce_select_out = uv_debounce_select;
  assign overvoltage_debounce_select_out = ov_debounce_select;
  assign per_regulator_monitor_enable_out = monitor_enable;

  // One copy of the supervision logic per regulator.
  for (genvar r = 0; r < regulator_monitor_pkg::NUM_REGULATORS; r++) begin : g_rail
    regulator_monitor_pkg::rail_state_t rail_state; // Supervision phase.
    regulator_monitor_pkg::rail_state_t next_rail_state; // Phase at the next tick.
    logic cmp_uv; // Synchronised undervoltage comparator.
    logic cmp_ov; // Synchronised overvoltage comparator.
    logic rail_on; // Synchronised switch-on level.
    logic rail_in_reg; // Synchronised in-regulation level.
    logic watch; // Enabled and past the start-up mask.
    logic [regulator_monitor_pkg::DB_CNT_W-1:0] uv_count; // Ticks of continuous UV.
    logic [regulator_monitor_pkg::DB_CNT_W-1:0] ov_count; // Ticks of continuous OV.
    logic uv_flag; // Debounced UV indicator.
    logic ov_flag; // Debounced OV indicator.

    assign cmp_uv = sync_stage2[2 * r];
    assign cmp_ov = sync_stage2[2 * r + 1];
    assign rail_on = sync_stage2[6 + r];
    assign rail_in_reg = sync_stage2[9 + r];

    // Start-up masking: a rail that turns on stays masked until it is in regulation.
    always_comb begin
      next_rail_state = rail_state;
      unique case (rail_state)
        regulator_monitor_pkg::RAIL_OFF: begin
          if (rail_on) begin
            next_rail_state = regulator_monitor_pkg::RAIL_RAMP;
          end
        end
        regulator_monitor_pkg::RAIL_RAMP: begin
          if (!rail_on) begin
            next_rail_state = regulator_monitor_pkg::RAIL_OFF;
          end else if (rail_in_reg) begin
            next_rail_state = regulator_monitor_pkg::RAIL_REGULATING;
          end
        end
        regulator_monitor_pkg::RAIL_REGULATING: begin
          if (!rail_on) begin
            next_rail_state = regulator_monitor_pkg::RAIL_OFF;
          end
        end
        default: begin
          next_rail_state = regulator_monitor_pkg::RAIL_OFF; // Illegal code recovers.
        end
      endcase
    end

    // The phase advances only on the control tick.
    always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
        rail_state <= regulator_monitor_pkg::RAIL_OFF;
      end else if (tick) begin
        rail_state <= next_rail_state;
      end
    end

    assign watch = monitor_enable[r] &
                   (rail_state == regulator_monitor_pkg::RAIL_REGULATING);

    // Undervoltage debounce; a drop of the comparator or of watch restarts the count.
    // The flag is a live level and falls as soon as the condition is gone.
    always_ff @(posedge clk_sys_in) begin
      if (rst_in || !watch || !cmp_uv) begin
        uv_count <= '0;
        uv_flag <= 1'b0;
      end else if (tick && uv_count < uv_target) begin
        uv_count <= uv_count + 1'b1;
        uv_flag <= 1'b0;
      end else begin
        uv_flag <= (uv_count >= uv_target);
      end
    end

    // Overvoltage debounce, built the same way with its own shared length.
    always_ff @(posedge clk_sys_in) begin
      if (rst_in || !watch || !cmp_ov) begin
        ov_count <= '0;
        ov_flag <= 1'b0;
      end else if (tick && ov_count < ov_target) begin
        ov_count <= ov_count + 1'b1;
        ov_flag <= 1'b0;
      end else begin
        ov_flag <= (ov_count >= ov_target);
      end
    end

    // Trip levels are registered so the analog side never sees a decode glitch.
    always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
        threshold_percent_out[r].undervoltage_percent <= regulator_monitor_pkg::UV_PERCENT_00;
        threshold_percent_out[r].overvoltage_percent <= regulator_monitor_pkg::OV_PERCENT_00;
      end else begin
        unique case (undervoltage_threshold_select_in[r])
          2'h0: threshold_percent_out[r].undervoltage_percent <=
                  regulator_monitor_pkg::UV_PERCENT_00;
          2'h1: threshold_percent_out[r].undervoltage_percent <=
                  regulator_monitor_pkg::UV_PERCENT_01;
          2'h2: threshold_percent_out[r].undervoltage_percent <=
                  regulator_monitor_pkg::UV_PERCENT_10;
          2'h3: threshold_percent_out[r].undervoltage_percent <=
                  regulator_monitor_pkg::UV_PERCENT_11;
        endcase
        unique case (overvoltage_threshold_select_in[r])
          2'h0: threshold_percent_out[r].overvoltage_percent <=
                  regulator_monitor_pkg::OV_PERCENT_00;
          2'h1: threshold_percent_out[r].overvoltage_percent <=
                  regulator_monitor_pkg::OV_PERCENT_01;
          2'h2: threshold_percent_out[r].overvoltage_percent <=
                  regulator_monitor_pkg::OV_PERCENT_10;
          2'h3: threshold_percent_out[r].overvoltage_percent <=
                  regulator_monitor_pkg::OV_PERCENT_11;
        endcase
      end
    end

    assign undervoltage_status_out[r] = uv_flag;
    assign overvoltage_status_out[r] = ov_flag;
    assign monitor_masked_out[r] = (rail_state != regulator_monitor_pkg::RAIL_REGULATING);
  end

endmodule

// ===== regulator_monitor_pkg.sv
// Shared constants and types for the regulator overvoltage and undervoltage monitor.
// Assumes a single 40 MHz system clock from which the 100 kHz control tick is divided.
package regulator_monitor_pkg;

  // Number of supervised buck regulators.
  localparam int NUM_REGULATORS = 3;

  // System clock rate and the rate of the slow control tick.
  localparam int CLK_SYS_HZ = 40_000_000;
  localparam int TICK_HZ = 100_000;

  // Cycles of the system clock per control tick, and the counter width for it.
  localparam int TICK_DIVIDE = CLK_SYS_HZ / TICK_HZ;
  localparam int TICK_CNT_W = $clog2(TICK_DIVIDE);
  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_DIVIDE - 1);

  // Length of one control tick in nanoseconds.
  localparam int TICK_PERIOD_NS = 1_000_000_000 / TICK_HZ;

  // Undervoltage debounce times in nanoseconds, one per select code.
  localparam int UV_DEBOUNCE_00_NS = 5_000;
  localparam int UV_DEBOUNCE_01_NS = 15_000;
  localparam int UV_DEBOUNCE_10_NS = 30_000;
  localparam int UV_DEBOUNCE_11_NS = 40_000;

  // Overvoltage debounce times in nanoseconds, one per select code.
  localparam int OV_DEBOUNCE_00_NS = 30_000;
  localparam int OV_DEBOUNCE_01_NS = 50_000;
  localparam int OV_DEBOUNCE_10_NS = 80_000;
  localparam int OV_DEBOUNCE_11_NS = 125_000;

  // Width of the debounce tick counters.
  localparam int DB_CNT_W = 4;

  // Debounce lengths in ticks; a least time rounds up to whole ticks.
  localparam logic [DB_CNT_W-1:0] UV_TICKS_00 =
    DB_CNT_W'((UV_DEBOUNCE_00_NS + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS);
  localparam logic [DB_CNT_W-1:0] UV_TICKS_01 =
    DB_CNT_W'((UV_DEBOUNCE_01_NS + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS);
  localparam logic [DB_CNT_W-1:0] UV_TICKS_10 =
    DB_CNT_W'((UV_DEBOUNCE_10_NS + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS);
  localparam logic [DB_CNT_W-1:0] UV_TICKS_11 =
    DB_CNT_W'((UV_DEBOUNCE_11_NS + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS);
  localparam logic [DB_CNT_W-1:0] OV_TICKS_00 =
    DB_CNT_W'((OV_DEBOUNCE_00_NS + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS);
  localparam logic [DB_CNT_W-1:0] OV_TICKS_01 =
    DB_CNT_W'((OV_DEBOUNCE_01_NS + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS);
  localparam logic [DB_CNT_W-1:0] OV_TICKS_10 =
    DB_CNT_W'((OV_DEBOUNCE_10_NS + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS);
  localparam logic [DB_CNT_W-1:0] OV_TICKS_11 =
    DB_CNT_W'((OV_DEBOUNCE_11_NS + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS);

  // Values after a full register reset.
  localparam logic [1:0] UV_DEBOUNCE_RESET = 2'h2;
  localparam logic [1:0] OV_DEBOUNCE_RESET = 2'h0;
  localparam logic [NUM_REGULATORS-1:0] MONITOR_ENABLE_RESET = 3'h7;

  // Trip levels in percent of nominal output.
  localparam logic [6:0] UV_PERCENT_00 = 7'h5F;
  localparam logic [6:0] UV_PERCENT_01 = 7'h5D;
  localparam logic [6:0] UV_PERCENT_10 = 7'h5B;
  localparam logic [6:0] UV_PERCENT_11 = 7'h59;
  localparam logic [6:0] OV_PERCENT_00 = 7'h69;
  localparam logic [6:0] OV_PERCENT_01 = 7'h6B;
  localparam logic [6:0] OV_PERCENT_10 = 7'h6D;
  localparam logic [6:0] OV_PERCENT_11 = 7'h6F;

  // Comparator outputs of one regulator; high means the fault condition is seen.
  typedef struct packed {
    logic overvoltage;
    logic undervoltage;
  } comparator_pair_t;

  // Trip level pair driven to the analog side of one regulator.
  typedef struct packed {
    logic [6:0] overvoltage_percent;
    logic [6:0] undervoltage_percent;
  } threshold_pair_t;

  // Supervision phase of one regulator.
  typedef enum logic [1:0] {
    RAIL_OFF = 2'b00,
    RAIL_RAMP = 2'b01,
    RAIL_REGULATING = 2'b10
  } rail_state_t;

endpackage

// ===== rail_comparator_model.sv
// Behavioural analog comparators, one undervoltage and one overvoltage per rail.
// Assumes the bench sets each rail's feedback level in percent of nominal.
`timescale 1ns/10ps
module rail_comparator_model (
  input regulator_monitor_pkg::threshold_pair_t [2:0] threshold_in, // Trip levels.
  input wire logic [2:0][6:0] level_in, // Rail level in percent.
  output regulator_monitor_pkg::comparator_pair_t [2:0] comparator_out // Fault levels.
);
  // A comparator trips only on a strict crossing, so a level at the trip point is healthy.
  always_comb begin
    for (int r = 0; r < 3; r++) begin
      comparator_out[r].undervoltage = level_in[r] < threshold_in[r].undervoltage_percent;
      comparator_out[r].overvoltage = level_in[r] > threshold_in[r].overvoltage_percent;
    end
  end
endmodule

// ===== regulator_ov_uv_monitor_asserts.sv
// Port-level checker for the regulator monitor, bound to every instance.
// Assumes the select codes stay steady while a fault is being debounced.
`timescale 1ns/10ps
module regulator_ov_uv_monitor_asserts (
  input wire logic clk_sys_in, // System clock.
  input wire logic rst_in, // Synchronous reset.
  input regulator_monitor_pkg::comparator_pair_t [2:0] comparator_in, // Comparators.
  input wire logic [2:0][1:0] undervoltage_threshold_select_in, // UV level codes.
  input wire logic [2:0][1:0] overvoltage_threshold_select_in, // OV level codes.
  input wire logic debounce_write_in, // Debounce strobe.
  input wire logic [1:0] undervoltage_debounce_select_in, // UV debounce data.
  input wire logic [1:0] overvoltage_debounce_select_in, // OV debounce data.
  input wire logic secure_protect_in, // Protection level.
  input wire logic monitor_enable_write_in, // Enable strobe.
  input wire logic monitor_enable_secure_in, // Secure flag.
  input wire logic [2:0] monitor_enable_wdata_in, // Enable data.
  input regulator_monitor_pkg::threshold_pair_t [2:0] threshold_percent_out, // Trip levels.
  input wire logic [1:0] undervoltage_debounce_select_out, // UV debounce code.
  input wire logic [1:0] overvoltage_debounce_select_out, // OV debounce code.
  input wire logic [2:0] per_regulator_monitor_enable_out, // Enables.
  input wire logic [2:0] monitor_masked_out, // Masks.
  input wire logic [2:0] undervoltage_status_out, // UV flags.
  input wire logic [2:0] overvoltage_status_out // OV flags.
);
  // Least run in cycles before a flag may rise: a tick short, plus the synchroniser.
  localparam int UV_MIN[4] = '{2, 402, 802, 1202};
  localparam int OV_MIN[4] = '{802, 1602, 2802, 4802};
  int uv_run; // Cycles of unbroken undervoltage on rail 0.
  int ov_run; // Cycles of unbroken overvoltage on rail 0.
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Any drop of a comparator restarts its run; saturation keeps the count bounded.
  always_ff @(posedge clk_sys_in) begin
    uv_run <= (rst_in || !comparator_in[0].undervoltage) ? 0 : uv_run + (uv_run < 60000);
    ov_run <= (rst_in || !comparator_in[0].overvoltage) ? 0 : ov_run + (ov_run < 60000);
  end
  property p_uv_level;
    !$past(rst_in) |-> threshold_percent_out[0].undervoltage_percent ==
      7'h5F - {4'h0, $past(undervoltage_threshold_select_in[0]), 1'b0};
  endproperty
  a_uv_level: assert property (p_uv_level) else $error("uv level wrong");
  property p_ov_level;
    !$past(rst_in) |-> threshold_percent_out[2].overvoltage_percent ==
      7'h69 + {4'h0, $past(overvoltage_threshold_select_in[2]), 1'b0};
  endproperty
  a_ov_level: assert property (p_ov_level) else $error("ov level wrong");
  property p_db_load;
    debounce_write_in |=>
      undervoltage_debounce_select_out == $past(undervoltage_debounce_select_in) &&
      overvoltage_debounce_select_out == $past(overvoltage_debounce_select_in);
  endproperty
  a_db_load: assert property (p_db_load) else $error("debounce load wrong");
  property p_reset_values;
    $fell(rst_in) |-> undervoltage_debounce_select_out == 2'h2 &&
      overvoltage_debounce_select_out == 2'h0 && per_regulator_monitor_enable_out == 3'h7;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset value wrong");
  property p_en_refused;
    monitor_enable_write_in && secure_protect_in && !monitor_enable_secure_in
      |=> $stable(per_regulator_monitor_enable_out);
  endproperty
  a_en_refused: assert property (p_en_refused) else $error("plain write taken");
  property p_en_write;
    monitor_enable_write_in && (!secure_protect_in || monitor_enable_secure_in)
      |=> per_regulator_monitor_enable_out == $past(monitor_enable_wdata_in);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write lost");
  property p_off_clear;
    !per_regulator_monitor_enable_out[0] |=>
      !undervoltage_status_out[0] && !overvoltage_status_out[0];
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("status while off");
  property p_mask_quiet;
    monitor_masked_out[0] |=> !undervoltage_status_out[0] && !overvoltage_status_out[0];
  endproperty
  a_mask_quiet: assert property (p_mask_quiet) else $error("status while masked");
  property p_uv_time;
    $rose(undervoltage_status_out[0]) |-> uv_run >= UV_MIN[undervoltage_debounce_select_out];
  endproperty
  a_uv_time: assert property (p_uv_time) else $error("uv flag early");
  property p_ov_time;
    $rose(overvoltage_status_out[0]) |-> ov_run >= OV_MIN[overvoltage_debounce_select_out];
  endproperty
  a_ov_time: assert property (p_ov_time) else $error("ov flag early");
  c_uv: cover property ($rose(undervoltage_status_out[0]));
  c_ov: cover property ($rose(overvoltage_status_out[0]));
  c_secure: cover property (monitor_enable_write_in && secure_protect_in &&
    monitor_enable_secure_in);
endmodule
bind regulator_ov_uv_monitor regulator_ov_uv_monitor_asserts regulator_ov_uv_monitor_asserts_i (
  .clk_sys_in, .rst_in, .comparator_in, .undervoltage_threshold_select_in,
  .overvoltage_threshold_select_in, .debounce_write_in, .undervoltage_debounce_select_in,
  .overvoltage_debounce_select_in, .secure_protect_in, .monitor_enable_write_in,
  .monitor_enable_secure_in, .monitor_enable_wdata_in, .threshold_percent_out,
  .undervoltage_debounce_select_out, .overvoltage_debounce_select_out,
  .per_regulator_monitor_enable_out, .monitor_masked_out, .undervoltage_status_out,
  .overvoltage_status_out);

// ===== regulator_ov_uv_monitor_test.sv
// Self-checking bench for the regulator monitor with a comparator model on the analog side.
// Assumes the package constants and a 40 MHz clock; the bench model works in integers.
`timescale 1ns/10ps
module regulator_ov_uv_monitor_test;
  logic clk_sys_in = 1'b0; // System clock.
  logic rst_in = 1'b1; // Reset, held at start.
  regulator_monitor_pkg::comparator_pair_t [2:0] comp; // From the comparator model.
  regulator_monitor_pkg::threshold_pair_t [2:0] thr; // Trip levels.
  logic [2:0] rail_on = 3'h0, in_reg = 3'h0, en_data = 3'h0, en_q, masked, uv_st, ov_st;
  logic [2:0][1:0] uv_sel = '0, ov_sel = '0; // Level codes.
  logic [1:0] uv_db = 2'h0, ov_db = 2'h0, uv_db_q, ov_db_q; // Debounce codes.
  logic db_write = 1'b0, protect = 1'b0, en_write = 1'b0, en_secure = 1'b0; // Strobes.
  logic [2:0][6:0] level = {3{7'h64}}; // Rail levels, nominal at start.
  int bad_count = 0, n_compared = 0, seed = 32'h5AB227EE, exp_en = 7, cyc, t;
  int uv_ns[$] = '{5000, 15000, 30000, 40000}; // Debounce times per code.
  int ov_ns[$] = '{30000, 50000, 80000, 125000};
  regulator_ov_uv_monitor regulator_ov_uv_monitor_i (.clk_sys_in, .rst_in, .comparator_in(comp),
    .regulator_on_in(rail_on), .in_regulation_in(in_reg),
    .undervoltage_threshold_select_in(uv_sel), .overvoltage_threshold_select_in(ov_sel),
    .debounce_write_in(db_write), .undervoltage_debounce_select_in(uv_db),
    .overvoltage_debounce_select_in(ov_db), .secure_protect_in(protect),
    .monitor_enable_write_in(en_write), .monitor_enable_secure_in(en_secure),
    .monitor_enable_wdata_in(en_data), .threshold_percent_out(thr),
    .undervoltage_debounce_select_out(uv_db_q), .overvoltage_debounce_select_out(ov_db_q),
    .per_regulator_monitor_enable_out(en_q), .monitor_masked_out(masked),
    .undervoltage_status_out(uv_st), .overvoltage_status_out(ov_st));
  rail_comparator_model rail_comparator_model_i (.threshold_in(thr), .level_in(level),
    .comparator_out(comp));
  // Free-running clock, 25 ns period.
  initial forever #12.5 clk_sys_in = ~clk_sys_in;
  // Inputs always move 2 ns after a rising edge, well clear of sampling.
  task step(input int n);
    repeat (n) begin
      @(posedge clk_sys_in);
      #2;
    end
  endtask
  // Full 32-bit operands, so integer expectations are never cut short.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("counts: %0d compared, %0d wrong", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Condition 0 uv flag, 1 ov flag, 2 unmasked, 3 both flags low, all on rail 0.
  function logic flag(input int w);
    case (w)
      0: return uv_st[0] === 1'b1;
      1: return ov_st[0] === 1'b1;
      2: return masked[0] === 1'b0;
      default: return {uv_st[0], ov_st[0]} === 2'h0;
    endcase
  endfunction
  // A bound that runs out is a failure and ends the run at once.
  task wait_for(input int w, input int bound);
    cyc = 0;
    while (!flag(w)) begin
      if (cyc == bound) begin
        chk(cyc, bound + 1);
        end_of_test;
      end
      step(1);
      cyc++;
    end
  endtask
  // The model takes an enable write only when unprotected or secure.
  task en_wr(input logic [2:0] d, input logic s);
    en_write = 1'b1;
    en_secure = s;
    en_data = d;
    if (!protect || s) exp_en = d;
    step(1);
    en_write = 1'b0;
    chk(en_q, exp_en);
    step(1);
  endtask
  task db_wr(input logic [1:0] u, input logic [1:0] o);
    db_write = 1'b1;
    uv_db = u;
    ov_db = o;
    step(1);
    db_write = 1'b0;
    chk({uv_db_q, ov_db_q}, {u, o});
    step(1);
  endtask
  // Drive rail 0 to a level, time the flag against the tick count, then restore it.
  task fault_time(input logic [6:0] lv, input int w, input int ns);
    t = (ns + 9999) / 10000;
    level[0] = lv;
    wait_for(w, t * 400 + 20);
    chk(cyc >= (t - 1) * 400 && cyc <= t * 400 + 8, 1);
    level[0] = 7'h64;
    wait_for(3, 8);
    step(10);
  endtask
  initial begin
    step(12);
    rst_in = 1'b0;
    chk({uv_db_q, ov_db_q}, 4'h8);
    chk(en_q, 3'h7);
    chk({masked, uv_st, ov_st}, 9'h1C0);
    chk(thr[1], {7'h69, 7'h5F});
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 3; r++) begin
        uv_sel[r] = 2'((c + r) % 4);
        ov_sel[r] = 2'((c + r + 1) % 4);
      end
      step(1);
      for (int r = 0; r < 3; r++) begin
        chk(thr[r].undervoltage_percent, 95 - 2 * ((c + r) % 4));
        chk(thr[r].overvoltage_percent, 105 + 2 * ((c + r + 1) % 4));
      end
    end
    uv_sel = '0;
    ov_sel = '0;
    for (int c = 0; c < 4; c++) db_wr(c, 3 - c);
    $display("test codes done");
    en_wr(3'($random(seed)), 1'b0);
    protect = 1'b1;
    en_wr(~exp_en, 1'b0);
    en_wr(3'h7, 1'b1);
    protect = 1'b0;
    $display("test enables done");
    rail_on = 3'h7;
    // A deep undervoltage during the ramp outlasts the 40 us debounce and must stay hidden.
    level[0] = 7'h55;
    step(1700);
    chk(masked, 3'h7);
    chk(uv_st, 3'h0);
    level[0] = 7'h64;
    step(10);
    in_reg = 3'h7;
    wait_for(2, 810);
    step(3);
    chk(masked, 3'h0);
    $display("test masking done");
    for (int c = 0; c < 4; c++) begin
      db_wr(c, c);
      fault_time(7'h55, 0, uv_ns[c]);
      fault_time(7'h73, 1, ov_ns[c]);
    end
    $display("test debounce done");
    db_wr(3, 0);
    // Short excursions hold at most one tick each; only an unbroken run may count to four.
    for (int g = 0; g < 8; g++) begin
      level[0] = 7'h55;
      step(300);
      chk(uv_st, 3'h0);
      level[0] = 7'h64;
      step(20);
    end
    db_wr(0, 0);
    level[0] = 7'h55;
    wait_for(0, 900);
    en_wr(3'h6, 1'b0);
    chk({uv_st[0], ov_st[0]}, 2'h0);
    level[0] = 7'h64;
    $display("test disable done");
    // A reset in mid-run must bring back the defaults over the values written above.
    rst_in = 1'b1;
    step(2);
    rst_in = 1'b0;
    chk({uv_db_q, ov_db_q}, 4'h8);
    chk({en_q, masked}, 6'h3F);
    $display("test second reset done");
    end_of_test;
  end
endmodule
